// ===== rtl/sesr_pkg.sv
// Package for the stamp and event source register bank
// Functional notes
// [RQ1] Per-axis stamp bits, default 1, put the data-enable pin into that axis LSB.
// [RQ2] Sensor select: 0 stamps gyroscope axes, 1 stamps accelerometer axes (code: only if the accel extend bit is also 1).
// [RQ3] Accel extend bit, default 0, extends data-enable function to the accelerometer.
// [RQ4] Polarity bit: 0 active low (default), 1 active high.
// [RQ5] I3C disable bit, default 0; 1 disables only the I3C interface.
// [RQ6] Host always writes zero to the control register's least significant bit.
// [RQ7] Host should set I3C disable when I3C is unused.
// [RQ8] Timestamp enable bit, default 0, runs the timestamp counter.
// [RQ9] Near-wrap flag rises when the counter overflows within 6.4 ms.
// [RQ10] Aggregate source reports near-wrap, activity, orientation, taps, wake-up, free-fall.
// [RQ11] Orientation-change flag set on a position change.
// [RQ12] Activity-change flag appears in aggregate and wake-up source registers.
// [RQ13] Sleep-state bit reads 0 in activity, 1 in inactivity.
// [RQ14] Global and per-axis wake-up flags, set on wake-up detection.
// [RQ15] Free-fall flag set when free fall is detected.
// [RQ16] Tap-any flag set on any tap event.
// [RQ17] Separate single-tap and double-tap flags.
// [RQ18] Tap sign: 0 positive, 1 negative acceleration.
// [RQ19] Per-axis tap flags set on a tap on that axis.
// [RQ20] Host writes to the source registers have no effect.
package sesr_pkg;
	localparam logic [7:0] SESR_ADDR_STAMP = 8'h18;
	localparam logic [7:0] SESR_ADDR_TSCTL = 8'h19;
	localparam logic [7:0] SESR_ADDR_AGG   = 8'h1a;
	localparam logic [7:0] SESR_ADDR_WAKE  = 8'h1b;
	localparam logic [7:0] SESR_ADDR_TAP   = 8'h1c;
	localparam logic [7:0] SESR_STAMP_RST  = 8'he0;
	localparam logic [7:0] SESR_TSCTL_RST  = 8'h00;
	localparam logic [7:0] SESR_STAMP_MASK = 8'hfe;
	localparam logic [7:0] SESR_TSCTL_MASK = 8'h20;
	localparam int         SESR_TS_EN_BIT  = 5;
	localparam int         SESR_I3C_BIT    = 1;
	localparam int         SESR_POL_BIT    = 2;
	localparam int         SESR_XLEN_BIT   = 3;
	localparam int         SESR_SEL_BIT    = 4;
	localparam int         SESR_AXIS_LO    = 5;
	localparam int         SESR_AXES       = 3;
	localparam int         SESR_TS_W       = 32;
	localparam longint     SESR_CLK_HZ     = 20000000;
	localparam longint     SESR_WRAP_NS    = 6400000;
	localparam longint     SESR_WRAP_CYC   = SESR_WRAP_NS * SESR_CLK_HZ / 1000000000;
	localparam logic [SESR_TS_W-1:0] SESR_WRAP_AT =
		SESR_TS_W'(64'h0000_0001_0000_0000 - SESR_WRAP_CYC);

	typedef struct packed {
		logic       near_wrap;
		logic       activity_change;
		logic       orientation_change;
		logic       double_tap;
		logic       single_tap;
		logic       wakeup;
		logic       freefall;
		logic       sleep_state;
		logic [2:0] wakeup_xyz;
		logic       tap_sign;
		logic [2:0] tap_xyz;
	} sesr_evt_t;

	typedef struct packed {
		logic [2:0] gyro_axes;
		logic [2:0] accel_axes;
		logic       pin_active;
		logic       i3c_off;
	} sesr_stamp_t;
endpackage

// ===== rtl/sesr_regs.sv
// Stamp control, timestamp control and event source register bank
`timescale 1ns/10ps
`default_nettype none
module sesr_regs
	import sesr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	output var  logic [7:0]  rdata,
	input  wire logic        data_enable_pin,
	input  wire sesr_evt_t   evt,
	output var  sesr_stamp_t stamp,
	output var  logic [31:0] ts_count
);
	logic [7:0]  stamp_reg;
	logic [7:0]  tsctl_reg;
	logic [1:0]  pin_sync;
	logic        near_wrap;
	sesr_evt_t   evt_q;

	wire         hit_stamp  = addr == SESR_ADDR_STAMP;
	wire         hit_tsctl  = addr == SESR_ADDR_TSCTL;
	wire         ts_run     = tsctl_reg[SESR_TS_EN_BIT];
	wire         pin_level  = pin_sync[1] ~^ stamp_reg[SESR_POL_BIT]; // RQ4
	wire         accel_on   = stamp_reg[SESR_SEL_BIT] & stamp_reg[SESR_XLEN_BIT]; // RQ3
	wire [2:0]   axes       = stamp_reg[SESR_AXIS_LO +: SESR_AXES]; // RQ1
	wire [7:0]   agg_val    = {evt_q.near_wrap, 1'b0, evt_q.activity_change,
		evt_q.orientation_change, evt_q.double_tap, evt_q.single_tap,
		evt_q.wakeup, evt_q.freefall}; // RQ10 RQ11 RQ17
	wire [7:0]   wake_val   = {1'b0, evt_q.activity_change, evt_q.freefall,
		evt_q.sleep_state, evt_q.wakeup, evt_q.wakeup_xyz}; // RQ12 RQ13 RQ14 RQ15
	wire [7:0]   tap_val    = {1'b0, evt_q.single_tap | evt_q.double_tap,
		evt_q.single_tap, evt_q.double_tap, evt_q.tap_sign, evt_q.tap_xyz}; // RQ16 RQ17 RQ18 RQ19
	wire [7:0]   next_rdata =
		hit_stamp ? stamp_reg :
		hit_tsctl ? tsctl_reg :
		addr == SESR_ADDR_AGG  ? agg_val :
		addr == SESR_ADDR_WAKE ? wake_val :
		addr == SESR_ADDR_TAP  ? tap_val : 8'h00;
	wire         next_near  = ts_run && ts_count >= SESR_WRAP_AT; // RQ9

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stamp_reg <= SESR_STAMP_RST; // RQ1
			tsctl_reg <= SESR_TSCTL_RST;
		end else if (wr_en && hit_stamp) begin
			stamp_reg <= wdata & SESR_STAMP_MASK; // RQ6
		end else if (wr_en && hit_tsctl) begin
			tsctl_reg <= wdata & SESR_TSCTL_MASK; // RQ8
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_sync  <= 2'b00;
			evt_q     <= '0;
			ts_count  <= '0;
			near_wrap <= 1'b0;
			rdata     <= 8'h00;
			stamp     <= '0;
		end else begin
			pin_sync  <= {pin_sync[0], data_enable_pin};
			evt_q     <= evt; // RQ20
			evt_q.near_wrap <= near_wrap; // RQ9
			near_wrap <= next_near;
			if (ts_run)
				ts_count <= ts_count + 32'h0000_0001; // RQ8
			if (rd_en)
				rdata <= next_rdata;
			stamp.gyro_axes  <= (stamp_reg[SESR_SEL_BIT] ? 3'b000 : axes)
				& {3{pin_level}}; // RQ2
			stamp.accel_axes <= (accel_on ? axes : 3'b000) & {3{pin_level}};
			stamp.pin_active <= pin_level;
			stamp.i3c_off    <= stamp_reg[SESR_I3C_BIT]; // RQ5
		end
	end

	a_stamp_lsb_zero: assert property (@(posedge clk) disable iff (sys_rst)
		stamp_reg[0] == 1'b0) else $error("stamp register lsb set"); // RQ6
	a_tap_any_or: assert property (@(posedge clk) disable iff (sys_rst)
		rd_en && addr == SESR_ADDR_TAP |=> rdata[6] == (rdata[5] | rdata[4]))
		else $error("tap any flag mismatch"); // RQ16
	a_ts_counts: assert property (@(posedge clk) disable iff (sys_rst)
		ts_run ##1 ts_run |-> ts_count == $past(ts_count) + 32'h0000_0001)
		else $error("timestamp not counting"); // RQ8
	a_ts_holds: assert property (@(posedge clk) disable iff (sys_rst)
		!ts_run ##1 !ts_run |-> $stable(ts_count))
		else $error("timestamp moved while off"); // RQ8
	a_wrap_flag: assert property (@(posedge clk) disable iff (sys_rst)
		next_near |-> ##2 evt_q.near_wrap)
		else $error("near wrap flag missing"); // RQ9
	a_gyro_select: assert property (@(posedge clk) disable iff (sys_rst)
		stamp_reg[SESR_SEL_BIT] |=> stamp.gyro_axes == 3'b000)
		else $error("gyro stamped while accel selected"); // RQ2
	a_accel_gate: assert property (@(posedge clk) disable iff (sys_rst)
		!stamp_reg[SESR_XLEN_BIT] |=> stamp.accel_axes == 3'b000)
		else $error("accel stamped without extend"); // RQ3
	a_wake_mirror: assert property (@(posedge clk) disable iff (sys_rst)
		rd_en && addr == SESR_ADDR_WAKE |=>
		rdata[6] == $past(evt_q.activity_change)
		&& rdata[5] == $past(evt_q.freefall))
		else $error("wake source mismatch"); // RQ12
	a_src_readonly: assert property (@(posedge clk) disable iff (sys_rst)
		wr_en && addr == SESR_ADDR_AGG |=> $stable(stamp_reg)
		&& $stable(tsctl_reg)) else $error("source write had effect"); // RQ20
	a_i3c_follow: assert property (@(posedge clk) disable iff (sys_rst)
		stamp_reg[SESR_I3C_BIT] |=> stamp.i3c_off)
		else $error("i3c disable not applied"); // RQ5
endmodule
`default_nettype wire

// ===== tb/sesr_host.sv
// Host model driving register reads and writes
`timescale 1ns/10ps
`default_nettype none
module sesr_host (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output var  logic       wr_en,
	output var  logic       rd_en,
	output var  logic [7:0] addr,
	output var  logic [7:0] wdata
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		wr_en = 1'b1;
		addr = a;
		wdata = (a == 8'h18) ? {d[7:1], 1'b0} : d;
		@(posedge clk);
		#1;
		wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		rd_en = 1'b1;
		addr = a;
		@(posedge clk);
		#1;
		rd_en = 1'b0;
		d = rdata;
	endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Testbench for the stamp and event source register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
	import sesr_pkg::*;
	logic        clk, sys_rst, wr_en, rd_en, pin;
	logic [7:0]  addr, wdata, rdata, rv;
	logic [31:0] ts_count, t0;
	sesr_evt_t   evt;
	sesr_stamp_t stamp;
	int          bad_count, cmp_count;
	sesr_regs dut (.clk(clk), .sys_rst(sys_rst), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wdata(wdata), .rdata(rdata), .data_enable_pin(pin),
		.evt(evt), .stamp(stamp), .ts_count(ts_count));
	sesr_host host (.clk(clk), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wdata(wdata));
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s exp %h saw %h", n, e, s);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d bad %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic pause();
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic t_reset();
		host.rd(8'h18, rv);
		chk("stamp_ctl", rv, 8'he0);
		host.rd(8'h19, rv);
		chk("ts_ctl", rv, 8'h00);
	endtask
	task automatic t_stamp();
		host.wr(8'h18, 8'h9f);
		host.rd(8'h18, rv);
		chk("stamp_ctl", rv, 8'h9e);
		pin = 1'b1;
		pause();
		chk("accel_stamp", stamp, 8'h13);
		pin = 1'b0;
		pause();
		chk("pin_idle", stamp.pin_active, 1'b0);
		host.wr(8'h18, 8'h40);
		pause();
		chk("gyro_stamp", stamp, 8'h42);
	endtask
	task automatic t_events();
		sesr_evt_t   p[2];
		logic [23:0] e[2];
		p = '{15'b010101011011010, 15'b001010100100101};
		e = '{24'h2a_5d5a, 24'h15_2265};
		for (int i = 0; i < 2; i++) begin
			evt = p[i];
			for (int k = 0; k < 3; k++) begin
				host.rd(8'h1a + 8'(k), rv);
				chk("source", rv, e[i][23-8*k -: 8]);
			end
		end
		host.wr(8'h1c, 8'h00);
		host.rd(8'h1c, rv);
		chk("tap_ro", rv, 8'h65);
		host.rd(8'h20, rv);
		chk("unmapped", rv, 8'h00);
	endtask
	task automatic t_ts();
		host.wr(8'h19, 8'hff);
		host.rd(8'h19, rv);
		chk("ts_ctl", rv, 8'h20);
		t0 = ts_count;
		repeat (10) @(posedge clk);
		#1;
		chk("ts_step", ts_count - t0, 32'h0000_000a);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		sys_rst = 1'b1;
		pin = 1'b0;
		evt = '0;
		bad_count = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		t_reset();
		t_stamp();
		t_events();
		t_ts();
		end_sim();
	end
endmodule
`default_nettype wire
